// ===== hdl/uotg_params.svh
// Offsets, field positions, reset values and timing counts of the OTG session block.
`ifndef UOTG_PARAMS_SVH
`define UOTG_PARAMS_SVH
`define UOTG_OFS_IRQ_FLAG   4'h0
`define UOTG_OFS_IRQ_EN     4'h4
`define UOTG_OFS_STATUS     4'h8
`define UOTG_OFS_CONTROL    4'hC
`define UOTG_EVT_ID         7
`define UOTG_EVT_TICK       6
`define UOTG_EVT_LINE       5
`define UOTG_EVT_ACTV       4
`define UOTG_EVT_SESSION_VALID_STATUS      3
`define UOTG_EVT_SESSION_END_STATUS     2
`define UOTG_EVT_A_VBUS_VALID_STATUS     0
`define UOTG_IMPL_MASK      8'hFD
`define UOTG_STAT_MASK      8'hAD
`define UOTG_RST_BYTE       8'h00
`define UOTG_CLK_HZ         25000000
`define UOTG_TICK_US        1000
`define UOTG_TICK_CYC       ((`UOTG_CLK_HZ / 1000000) * `UOTG_TICK_US)
`endif

// ===== hdl/uotg_pkg.sv
// Types shared by the OTG session control block.
package uotg_pkg;
    typedef logic [7:0] uotg_byte_t;
    typedef struct packed {
        logic       id;
        logic       session_valid_status;
        logic       session_end_status;
        logic       a_vbus_valid_status;
        logic [1:0] line;
        logic       activity;
    } uotg_sense_s;
    typedef struct packed {
        logic dp_pullup;
        logic dm_pullup;
        logic dp_pulldown;
        logic dm_pulldown;
        logic vbus_power;
        logic vbus_charge;
        logic vbus_discharge;
    } uotg_drive_s;
endpackage

// ===== hdl/uotg_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
module uotg_sync
    import uotg_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic q_ff;

    // Stage one is only read by stage two, so metastability cannot spread.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff  <= 1'b0;
        end else begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                q_ff <= s3_ff;
            end
        end
    end

    assign q_out = q_ff;
endmodule

// ===== hdl/uotg_session.sv
// OTG session control: event flags, enables, session status and line drive control.
`timescale 1ns/10ps
`include "uotg_params.svh"

// Functional notes
// - Bits 31..8 read zero, ignore writes.
// - Bit 7 enables cable identity change interrupt.
// - Bit 6 enables millisecond tick interrupt.
// - Bit 5 enables line stable interrupt.
// - Bit 4 enables bus activity interrupt.
// - Bit 3 enables session valid interrupt.
// - Bit 2 session end enable; bit 1 zero.
// - Bit 0 enables A-device VBUS valid interrupt.
// - Status bit 7 shows identity pin.
// - Status bit 5: line stable 1 ms.
// - Status bit 3: VBUS above session valid.
// - Status bit 2: B-device session end.
// - Status bit 0: A-device VBUS valid.
// - Control bit 7 drives D+ pull-up.
// - Control bit 6 drives D- pull-up.
// - Bits 5,4 drive D+/D- pull-downs.
// - Control bit 3 requests VBUS power.
// - Bit 2 selects software or hardware pulls.
// - Control bit 1 enables VBUS charge.
// - Control bit 0 enables VBUS discharge.
// - All implemented bits reset to zero.
// - Flags set by hardware, write-one clears.
// - Line flag on new stable line state.
module uotg_session
    import uotg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    input  wire uotg_sense_s sense_in,
    input  wire uotg_drive_s hw_pull_in,
    output uotg_drive_s      drive_out,
    output logic             irq_out
);
    localparam int TICK_CYC = `UOTG_TICK_CYC;

    uotg_byte_t  flag_ff;
    uotg_byte_t  en_ff;
    uotg_byte_t  ctl_ff;
    uotg_byte_t  nxt_flag;
    logic [31:0] rdata_ff;
    logic [14:0] tick_cnt_ff;
    logic [14:0] stable_cnt_ff;
    logic        stable_ff;
    logic [1:0]  line_prev_ff;
    logic [1:0]  line_rec_ff;
    logic        id_prev_ff;
    logic        session_valid_status_prev_ff;
    logic        session_end_status_prev_ff;
    logic        a_vbus_valid_status_prev_ff;
    logic        actv_prev_ff;
    uotg_drive_s drive_ff;
    uotg_sense_s sense_sync;

    // Every sensed pin passes the three-stage synchroniser.
    localparam int NSENSE = $bits(uotg_sense_s);
    logic [NSENSE-1:0] sense_raw;
    logic [NSENSE-1:0] sense_q;
    assign sense_raw  = sense_in;
    assign sense_sync = sense_q;
    genvar gi;
    generate
        for (gi = 0; gi < NSENSE; gi = gi + 1) begin : g_sync
            uotg_sync u_sync (
                .clk_in  (clk_in),
                .srst_in (srst_in),
                .d_in    (sense_raw[gi]),
                .q_out   (sense_q[gi])
            );
        end
    endgenerate

    // Address decode for the four word registers.
    wire sel_flag = (addr_in == `UOTG_OFS_IRQ_FLAG);
    wire sel_en   = (addr_in == `UOTG_OFS_IRQ_EN);
    wire sel_stat = (addr_in == `UOTG_OFS_STATUS);
    wire sel_ctl  = (addr_in == `UOTG_OFS_CONTROL);
    wire wr_flag  = wr_in && sel_flag;
    wire wr_en    = wr_in && sel_en;
    wire wr_ctl   = wr_in && sel_ctl;

    // Millisecond timer and line-stability counter.
    wire tick_done   = (tick_cnt_ff == 15'(TICK_CYC - 1));
    wire line_moved  = (sense_sync.line != line_prev_ff);
    wire stable_done = (stable_cnt_ff == 15'(TICK_CYC - 1));
    // Line flag only when the newly stable state differs from the last one.
    wire line_event  = stable_done && !line_moved && (sense_sync.line != line_rec_ff);

    // Raw hardware events, one per flag position.
    uotg_byte_t evt;
    assign evt[`UOTG_EVT_ID]     = sense_sync.id != id_prev_ff;
    assign evt[`UOTG_EVT_TICK]   = tick_done;
    assign evt[`UOTG_EVT_LINE]   = line_event;
    assign evt[`UOTG_EVT_ACTV]   = sense_sync.activity && !actv_prev_ff;
    assign evt[`UOTG_EVT_SESSION_VALID_STATUS]  = sense_sync.session_valid_status != session_valid_status_prev_ff;
    assign evt[`UOTG_EVT_SESSION_END_STATUS] = sense_sync.session_end_status != session_end_status_prev_ff;
    assign evt[1]                = 1'b0;
    assign evt[`UOTG_EVT_A_VBUS_VALID_STATUS] = sense_sync.a_vbus_valid_status != a_vbus_valid_status_prev_ff;

    // A set in the same cycle as a write-one clear wins, so no event is lost.
    assign nxt_flag = ((flag_ff & ~(wr_flag ? wdata_in[7:0] : 8'h00)) | evt)
                      & `UOTG_IMPL_MASK;

    // Each enable bit gates only its own flag onto the request.
    assign irq_out = |(flag_ff & en_ff);

    // Status byte from synchronised comparators and the stability detector.
    uotg_byte_t stat_byte;
    assign stat_byte[7] = sense_sync.id;
    assign stat_byte[6] = 1'b0;
    assign stat_byte[5] = stable_ff;
    assign stat_byte[4] = 1'b0;
    assign stat_byte[3] = sense_sync.session_valid_status;
    assign stat_byte[2] = sense_sync.session_end_status;
    assign stat_byte[1] = 1'b0;
    assign stat_byte[0] = sense_sync.a_vbus_valid_status;

    // Read multiplexer; upper bits and unmapped offsets read zero.
    wire [31:0] rd_mux = sel_flag ? {24'h000000, flag_ff} :
                         sel_en   ? {24'h000000, en_ff} :
                         sel_stat ? {24'h000000, stat_byte & `UOTG_STAT_MASK} :
                         sel_ctl  ? {24'h000000, ctl_ff} : 32'h00000000;

    // Pull resistors follow software only when software control is selected.
    wire sw_pull = ctl_ff[2];
    uotg_drive_s nxt_drive;
    assign nxt_drive.dp_pullup      = sw_pull ? ctl_ff[7] : hw_pull_in.dp_pullup;
    assign nxt_drive.dm_pullup      = sw_pull ? ctl_ff[6] : hw_pull_in.dm_pullup;
    assign nxt_drive.dp_pulldown    = sw_pull ? ctl_ff[5] : hw_pull_in.dp_pulldown;
    assign nxt_drive.dm_pulldown    = sw_pull ? ctl_ff[4] : hw_pull_in.dm_pulldown;
    assign nxt_drive.vbus_power     = ctl_ff[3];
    assign nxt_drive.vbus_charge    = ctl_ff[1];
    assign nxt_drive.vbus_discharge = ctl_ff[0];
    assign drive_out = drive_ff;

    // Software registers; only the low byte is stored.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flag_ff  <= `UOTG_RST_BYTE;
            en_ff    <= `UOTG_RST_BYTE;
            ctl_ff   <= `UOTG_RST_BYTE;
            rdata_ff <= 32'h00000000;
            drive_ff <= '0;
        end else begin
            flag_ff  <= nxt_flag;
            if (wr_en) begin
                en_ff <= wdata_in[7:0] & `UOTG_IMPL_MASK;
            end
            if (wr_ctl) begin
                ctl_ff <= wdata_in[7:0];
            end
            rdata_ff <= rd_in ? rd_mux : 32'h00000000;
            drive_ff <= nxt_drive;
        end
    end

    // Free-running millisecond timer.
    always_ff @(posedge clk_in) begin
        if (srst_in || tick_done) begin
            tick_cnt_ff <= 15'h0000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 15'h0001;
        end
    end

    // Line stability: counter restarts on any change of either line bit.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stable_cnt_ff <= 15'h0000;
            stable_ff     <= 1'b0;
            line_prev_ff  <= 2'h0;
            line_rec_ff   <= 2'h0;
        end else begin
            line_prev_ff <= sense_sync.line;
            if (line_moved) begin
                stable_cnt_ff <= 15'h0000;
                stable_ff     <= 1'b0;
            end else if (stable_done) begin
                stable_ff   <= 1'b1;
                line_rec_ff <= sense_sync.line;
            end else begin
                stable_cnt_ff <= stable_cnt_ff + 15'h0001;
            end
        end
    end

    // Previous comparator values for change detection. Reset to zero, so a level
    // already high when reset lifts reports one change.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            id_prev_ff     <= 1'b0;
            session_valid_status_prev_ff  <= 1'b0;
            session_end_status_prev_ff <= 1'b0;
            a_vbus_valid_status_prev_ff <= 1'b0;
            actv_prev_ff   <= 1'b0;
        end else begin
            id_prev_ff     <= sense_sync.id;
            session_valid_status_prev_ff  <= sense_sync.session_valid_status;
            session_end_status_prev_ff <= sense_sync.session_end_status;
            a_vbus_valid_status_prev_ff <= sense_sync.a_vbus_valid_status;
            actv_prev_ff   <= sense_sync.activity;
        end
    end

    assign rdata_out = rdata_ff;
endmodule

// ===== test/uotg_cable.sv
// Cable peer model: comparator, pin and hardware pull levels seen by the block.
`timescale 1ns/10ps
module uotg_cable
    import uotg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire uotg_sense_s sense_req_in,
    input  wire uotg_drive_s pull_req_in,
    output uotg_sense_s      sense_out,
    output uotg_drive_s      hw_pull_out
);
    // Levels move on a clock edge, as slow analog pins would settle.
    always_ff @(posedge clk_in) begin
        sense_out <= sense_req_in;
        hw_pull_out <= pull_req_in;
    end
endmodule

// ===== test/uotg_session_sva.sv
// Concurrent checks on the register port and drive outputs of the session block.
`timescale 1ns/10ps
module uotg_session_chk
    import uotg_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic [3:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire uotg_sense_s sense_in,
    input wire uotg_drive_s hw_pull_in,
    input wire uotg_drive_s drive_out,
    input wire logic        irq_out
);
    // One clock domain, so clocking and reset gating are declared once.
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (srst_in);
    AST_UPPER_ZERO: assert property (rdata_out[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_READ_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h00000000)
        else $error("read data outside read slot");
    AST_EN_BIT1: assert property (rd_in && addr_in == 4'h4 |=> !rdata_out[1])
        else $error("enable bit one reads high");
    AST_STAT_GAPS: assert property (rd_in && addr_in == 4'h8 |=> (rdata_out[7:0] & 8'h52) == 8'h00)
        else $error("unused status bit reads high");
    AST_VBUS_DRIVE: assert property (wr_in && addr_in == 4'hC |-> ##2
        drive_out.vbus_power == $past(wdata_in[3], 2))
        else $error("vbus power drive wrong");
    AST_VBUS_RES: assert property (wr_in && addr_in == 4'hC |-> ##2
        {drive_out.vbus_charge, drive_out.vbus_discharge} == $past(wdata_in[1:0], 2))
        else $error("vbus charge drive wrong");
    AST_SW_PULLS: assert property (wr_in && addr_in == 4'hC && wdata_in[2] |-> ##2
        drive_out[6:3] == $past(wdata_in[7:4], 2))
        else $error("software pull drive wrong");
    AST_IRQ_MASKED: assert property (wr_in && addr_in == 4'h4 && wdata_in[7:0] == 8'h00 |=> !irq_out)
        else $error("interrupt with all enables clear");
    AST_RESET_OUT: assert property (disable iff (1'b0) srst_in |=>
        drive_out == 7'h00 && !irq_out && rdata_out == 32'h00000000)
        else $error("outputs not cleared by reset");
endmodule
bind uotg_session uotg_session_chk uotg_session_chk_i (
    .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sense_in(sense_in),
    .hw_pull_in(hw_pull_in), .drive_out(drive_out), .irq_out(irq_out)
);

// ===== test/test_uotg_session.sv
// Self-checking bench of the OTG session block with a cable model on its sense side.
`timescale 1ns/10ps
module test_uotg_session
    import uotg_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    logic [31:0] rdata;
    logic        irq;
    uotg_sense_s sense_req = '0;
    uotg_sense_s sense;
    uotg_drive_s pull_req = '0;
    uotg_drive_s hw_pull;
    uotg_drive_s drive;
    logic [31:0] seed = 32'h786C1AA4;
    logic [31:0] exp_q[$];
    int          mismatches = 0;
    int          checks = 0;
    uotg_cable uotg_cable_i (.clk_in(clk_in), .sense_req_in(sense_req),
        .pull_req_in(pull_req), .sense_out(sense), .hw_pull_out(hw_pull));
    uotg_session uotg_session_i (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sense_in(sense),
        .hw_pull_in(hw_pull), .drive_out(drive), .irq_out(irq));
    // Free-running 25 MHz clock.
    initial forever #20 clk_in = ~clk_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] want);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(want);
        @(posedge clk_in);
        rd <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so the oldest note is taken then.
    always @(posedge clk_in) rd_d <= rd;
    always @(negedge clk_in) begin
        if (rd_d) begin
            check(rdata, exp_q.pop_front());
        end
    end
    // A hang would leave the verdict unprinted, so a bound cuts it short.
    initial begin
        cyc(60000);
        mismatches++;
        give_verdict();
    end
    initial begin
        logic [31:0] r;
        cyc(16);
        srst_in <= 1'b0;
        for (int a = 0; a < 16; a += 2) bus_rd(a[3:0], 32'h0);
        bus_wr(4'h4, 32'hFFFFFFFF);
        bus_rd(4'h4, 32'h000000FD);
        // Random control words with alternating pull ownership.
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            r = {seed[31:3], i[0], seed[1:0]};
            pull_req <= r[14:8];
            bus_wr(4'hC, r);
            bus_rd(4'hC, {24'h0, r[7:0]});
            cyc(6);
            check({25'h0, drive}, {25'h0, r[2] ? r[7:4] : r[14:11], r[3], r[1:0]});
        end
        // B cable with VBUS valid: identity, session valid and A-valid high.
        sense_req <= 7'b1101000;
        cyc(8);
        bus_wr(4'h8, 32'hFF);
        bus_rd(4'h8, 32'h89);
        bus_wr(4'h0, 32'h0);
        bus_rd(4'h0, 32'h89);
        for (int i = 0; i < 8; i++) begin
            bus_wr(4'h4, 32'h1 << i);
            @(negedge clk_in);
            check({31'h0, irq}, {31'h0, r[0] | 1'b1 ? 8'h89 >> i & 8'h01 : 1'b0});
        end
        bus_wr(4'h0, 32'hFF);
        bus_rd(4'h0, 32'h0);
        // Quiet line for over a millisecond: stable status and timer event only.
        cyc(25040);
        bus_rd(4'h8, 32'hA9);
        bus_rd(4'h0, 32'h40);
        bus_wr(4'h0, 32'hFF);
        sense_req <= 7'b1101011;
        cyc(8);
        bus_rd(4'h8, 32'h89);
        cyc(25040);
        bus_rd(4'h0, 32'h70);
        cyc(2);
        give_verdict();
    end
endmodule
